/* pdmc_consts.svh */
`ifndef PDMC_CONSTS_SVH
`define PDMC_CONSTS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define PDMC_IDX_STANDBY     16'hff38
`define PDMC_IDX_CLKDIV      16'hff3a
`define PDMC_IDX_HALT_HIGH   16'hff3c
`define PDMC_IDX_HALT_LOW    16'hff3d

// ****************************************************************
// Reset values and writable-bit masks.
// ****************************************************************
`define PDMC_RST_STANDBY     8'h08
`define PDMC_RST_CLKDIV      8'h00
`define PDMC_RST_HALT_HIGH   8'h3f
`define PDMC_RST_HALT_LOW    8'hff
`define PDMC_WMASK_STANDBY   8'hf9
`define PDMC_WMASK_CLKDIV    8'hc7

// ****************************************************************
// Field positions.
// ****************************************************************
`define PDMC_BIT_STBY_SEL    7
`define PDMC_WAIT_HI         6
`define PDMC_WAIT_LO         4
`define PDMC_BIT_BUS_HOLD    3
`define PDMC_BIT_PIN_DIS     7
`define PDMC_DIV_HI          2
`define PDMC_DIV_LO          0

// ****************************************************************
// Codes and counts.
// ****************************************************************
`define PDMC_WAIT_CODE_RSVD  3'h6
`define PDMC_WAIT_CODE_SHORT 3'h7
`define PDMC_WAIT_SHORT      16
`define PDMC_DIV_MAX         3'h5
`define PDMC_RESP_OKAY       2'h0
`define PDMC_RESP_SLVERR     2'h2

`endif

/* pdmc_pkg.sv */
package pdmc_pkg;

    // Power-down sequencer states.
    typedef enum logic [1:0] {
        PDMC_RUN,
        PDMC_SLEEP,
        PDMC_STANDBY,
        PDMC_WAKE
    } pdmc_state_type;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        PDMC_SEL_NONE,
        PDMC_SEL_STANDBY,
        PDMC_SEL_CLKDIV,
        PDMC_SEL_HALT_HIGH,
        PDMC_SEL_HALT_LOW
    } pdmc_sel_type;

endpackage

/* pdmc_power_down_ctrl.sv */
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_consts.svh"

module pdmc_power_down_ctrl #(
    parameter int ADDR_W    = 20,
    parameter int BUS_W     = 24,
    parameter int WAIT_W    = 19,
    parameter int WAIT_BASE = 8192,
    parameter int DIV_W     = 5
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              haltExec,
    input  wire logic              anyIrq,
    input  wire logic              extIrq,
    input  wire logic              hwStandbyN,
    input  wire logic              busCycleEnd,
    input  wire logic [BUS_W-1:0]  addrBusIn,
    input  wire logic [7:0]        busStrobesNIn,
    output logic [BUS_W-1:0]       addrBusOut,
    output logic                   addrBusOe,
    output logic [7:0]             busStrobesNOut,
    output logic                   busStrobesOe,
    output logic                   clkPinOut,
    output logic                   clkPinOe,
    output logic                   cpuHalted,
    output logic                   oscStopped,
    output logic                   serialAdcReset,
    output logic                   portsHighZ,
    output logic [15:0]            moduleHalt,
    output logic                   busMasterClkEn,
    output logic [2:0]             activeDivide
);

    // ************************************************************
    // Shared decoding.
    // ************************************************************

    // Maps a byte address onto one of the four registers.
    function automatic pdmc_pkg::pdmc_sel_type regSel(
        input logic [ADDR_W-1:0] addr
    );
        regSel = pdmc_pkg::PDMC_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[ADDR_W-1:2])
                (ADDR_W-2)'(`PDMC_IDX_STANDBY):
                    regSel = pdmc_pkg::PDMC_SEL_STANDBY;
                (ADDR_W-2)'(`PDMC_IDX_CLKDIV):
                    regSel = pdmc_pkg::PDMC_SEL_CLKDIV;
                (ADDR_W-2)'(`PDMC_IDX_HALT_HIGH):
                    regSel = pdmc_pkg::PDMC_SEL_HALT_HIGH;
                (ADDR_W-2)'(`PDMC_IDX_HALT_LOW):
                    regSel = pdmc_pkg::PDMC_SEL_HALT_LOW;
                default: regSel = pdmc_pkg::PDMC_SEL_NONE;
            endcase
        end
    endfunction

    // Settling-wait length for a wait-select code.
    function automatic logic [WAIT_W-1:0] waitLoad(input logic [2:0] code);
        case (code)
            `PDMC_WAIT_CODE_SHORT: waitLoad = WAIT_W'(`PDMC_WAIT_SHORT);
            `PDMC_WAIT_CODE_RSVD:  waitLoad = WAIT_W'(WAIT_BASE);
            default:               waitLoad = WAIT_W'(WAIT_BASE) << code;
        endcase
    endfunction

    // ************************************************************
    // State.
    // ************************************************************
    logic [7:0]               standby_reg,    standby_next;
    logic [7:0]               clkdiv_reg,     clkdiv_next;
    logic [7:0]               haltHigh_reg,   haltHigh_next;
    logic [7:0]               haltLow_reg,    haltLow_next;
    pdmc_pkg::pdmc_state_type state_reg,      state_next;
    logic [WAIT_W-1:0]        waitCnt_reg,    waitCnt_next;
    logic [2:0]               divide_reg,     divide_next;
    logic [DIV_W-1:0]         divCnt_reg,     divCnt_next;
    logic                     busEn_reg,      busEn_next;
    logic [BUS_W-1:0]         addrHold_reg,   addrHold_next;
    logic [7:0]               strobeHold_reg, strobeHold_next;
    logic                     pinHigh_reg,    pinHigh_next;
    logic                     bvalid_reg,     bvalid_next;
    logic [1:0]               bresp_reg,      bresp_next;
    logic                     rvalid_reg,     rvalid_next;
    logic [1:0]               rresp_reg,      rresp_next;
    logic [31:0]              rdata_reg,      rdata_next;

    logic                     wrTake;
    logic                     rdTake;
    logic                     inStandby;
    logic [2:0]               divSel;
    logic [DIV_W-1:0]         divMask;
    pdmc_pkg::pdmc_sel_type   wrSel;
    pdmc_pkg::pdmc_sel_type   rdSel;

    // ************************************************************
    // Bus handshakes.
    // ************************************************************

    // Address and data are taken together once no response is pending.
    assign wrTake        = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    assign rdTake        = s_axi_arvalid && !rvalid_reg;
    assign s_axi_awready = wrTake;
    assign s_axi_wready  = wrTake;
    assign s_axi_arready = !rvalid_reg;
    assign wrSel         = regSel(s_axi_awaddr);
    assign rdSel         = regSel(s_axi_araddr);

    // Response channels; an unmapped address answers with SLVERR.
    always_comb begin
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wrTake) begin
            bvalid_next = 1'b1;
            bresp_next  = (wrSel == pdmc_pkg::PDMC_SEL_NONE) ?
                          `PDMC_RESP_SLVERR : `PDMC_RESP_OKAY;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (rdTake) begin
            rvalid_next = 1'b1;
            rresp_next  = `PDMC_RESP_OKAY;
            case (rdSel)
                pdmc_pkg::PDMC_SEL_STANDBY:   rdata_next = {24'h0, standby_reg};
                pdmc_pkg::PDMC_SEL_CLKDIV:    rdata_next = {24'h0, clkdiv_reg};
                pdmc_pkg::PDMC_SEL_HALT_HIGH: rdata_next = {24'h0, haltHigh_reg};
                pdmc_pkg::PDMC_SEL_HALT_LOW:  rdata_next = {24'h0, haltLow_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = `PDMC_RESP_SLVERR;
                end
            endcase
        end
    end

    // ************************************************************
    // Control registers and sequencer.
    // ************************************************************
    assign inStandby = (state_reg == pdmc_pkg::PDMC_STANDBY) ||
                       (state_reg == pdmc_pkg::PDMC_WAKE);
    assign divSel    = clkdiv_reg[`PDMC_DIV_HI:`PDMC_DIV_LO];
    assign divMask   = DIV_W'((1 << divide_reg) - 1);

    // Register writes, mode transitions, wake wait and divider.
    always_comb begin
        standby_next    = standby_reg;
        clkdiv_next     = clkdiv_reg;
        haltHigh_next   = haltHigh_reg;
        haltLow_next    = haltLow_reg;
        state_next      = state_reg;
        waitCnt_next    = waitCnt_reg;
        divide_next     = divide_reg;
        divCnt_next     = divCnt_reg + DIV_W'(1);
        addrHold_next   = addrHold_reg;
        strobeHold_next = strobeHold_reg;
        if (wrTake && s_axi_wstrb[0]) begin
            case (wrSel)
                pdmc_pkg::PDMC_SEL_STANDBY: standby_next =
                    s_axi_wdata[7:0] & `PDMC_WMASK_STANDBY;
                pdmc_pkg::PDMC_SEL_CLKDIV: clkdiv_next =
                    s_axi_wdata[7:0] & `PDMC_WMASK_CLKDIV;
                pdmc_pkg::PDMC_SEL_HALT_HIGH: haltHigh_next = s_axi_wdata[7:0];
                pdmc_pkg::PDMC_SEL_HALT_LOW:  haltLow_next  = s_axi_wdata[7:0];
                default: ;
            endcase
        end
        // Divide change only between bus cycles; software standby holds it.
        if (busCycleEnd && !inStandby && divSel <= `PDMC_DIV_MAX) begin
            divide_next = divSel;
        end
        // Bus pins are sampled outside software standby, then frozen in standby.
        if (!inStandby) begin
            addrHold_next   = addrBusIn;
            strobeHold_next = busStrobesNIn;
        end
        case (state_reg)
            pdmc_pkg::PDMC_RUN: begin
                if (haltExec) begin
                    if (standby_reg[`PDMC_BIT_STBY_SEL]) begin
                        state_next = pdmc_pkg::PDMC_STANDBY;
                    end else begin
                        state_next = pdmc_pkg::PDMC_SLEEP;
                    end
                end
            end
            pdmc_pkg::PDMC_SLEEP: begin
                if (anyIrq || extIrq) begin
                    state_next = pdmc_pkg::PDMC_RUN;
                end
            end
            pdmc_pkg::PDMC_STANDBY: begin
                if (extIrq) begin
                    state_next   = pdmc_pkg::PDMC_WAKE;
                    waitCnt_next = waitLoad(
                        standby_reg[`PDMC_WAIT_HI:`PDMC_WAIT_LO]);
                end
            end
            pdmc_pkg::PDMC_WAKE: begin
                waitCnt_next = waitCnt_reg - WAIT_W'(1);
                if (waitCnt_reg <= WAIT_W'(1)) begin
                    state_next = pdmc_pkg::PDMC_RUN;
                end
            end
            default: state_next = pdmc_pkg::PDMC_RUN;
        endcase
        // Hardware standby overrides writes, sequencer and divide, and restores their resets.
        if (!hwStandbyN) begin
            standby_next  = `PDMC_RST_STANDBY;
            clkdiv_next   = `PDMC_RST_CLKDIV;
            haltHigh_next = `PDMC_RST_HALT_HIGH;
            haltLow_next  = `PDMC_RST_HALT_LOW;
            state_next    = pdmc_pkg::PDMC_RUN;
            waitCnt_next  = '0;
            divide_next   = 3'h0;
        end
    end

    // Bus master clock enable and clock pin level.
    always_comb begin
        busEn_next   = ((divCnt_reg & divMask) == divMask) &&
                       !inStandby && hwStandbyN;
        pinHigh_next = clkdiv_reg[`PDMC_BIT_PIN_DIS] || inStandby;
    end

    // Registers all state; rst_n loads the reset value into every register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_reg    <= `PDMC_RST_STANDBY;
            clkdiv_reg     <= `PDMC_RST_CLKDIV;
            haltHigh_reg   <= `PDMC_RST_HALT_HIGH;
            haltLow_reg    <= `PDMC_RST_HALT_LOW;
            state_reg      <= pdmc_pkg::PDMC_RUN;
            waitCnt_reg    <= '0;
            divide_reg     <= 3'h0;
            divCnt_reg     <= '0;
            busEn_reg      <= 1'b1;
            addrHold_reg   <= '0;
            strobeHold_reg <= 8'hff;
            pinHigh_reg    <= 1'b0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= `PDMC_RESP_OKAY;
            rvalid_reg     <= 1'b0;
            rresp_reg      <= `PDMC_RESP_OKAY;
            rdata_reg      <= 32'h0;
        end else begin
            standby_reg    <= standby_next;
            clkdiv_reg     <= clkdiv_next;
            haltHigh_reg   <= haltHigh_next;
            haltLow_reg    <= haltLow_next;
            state_reg      <= state_next;
            waitCnt_reg    <= waitCnt_next;
            divide_reg     <= divide_next;
            divCnt_reg     <= divCnt_next;
            busEn_reg      <= busEn_next;
            addrHold_reg   <= addrHold_next;
            strobeHold_reg <= strobeHold_next;
            pinHigh_reg    <= pinHigh_next;
            bvalid_reg     <= bvalid_next;
            bresp_reg      <= bresp_next;
            rvalid_reg     <= rvalid_next;
            rresp_reg      <= rresp_next;
            rdata_reg      <= rdata_next;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************

    // Sleep, divide and module halt come from independent state.
    assign cpuHalted      = (state_reg != pdmc_pkg::PDMC_RUN);
    assign oscStopped     = inStandby || !hwStandbyN;
    assign serialAdcReset = inStandby || !hwStandbyN;
    assign portsHighZ     = !hwStandbyN;
    assign moduleHalt     = {haltHigh_reg, haltLow_reg};
    assign busMasterClkEn = busEn_reg;
    assign activeDivide   = divide_reg;

    // External bus pins float in hardware standby, and in software standby without bus hold.
    assign addrBusOut     = addrHold_reg;
    assign busStrobesNOut = strobeHold_reg;
    assign addrBusOe      = hwStandbyN &&
                            !(inStandby && !standby_reg[`PDMC_BIT_BUS_HOLD]);
    assign busStrobesOe   = addrBusOe;

    // Clock pin follows the clock unless forced high, floats in hardware.
    assign clkPinOut      = ref_clk || pinHigh_reg;
    assign clkPinOe       = hwStandbyN;

    assign s_axi_bvalid   = bvalid_reg;
    assign s_axi_bresp    = bresp_reg;
    assign s_axi_rvalid   = rvalid_reg;
    assign s_axi_rresp    = rresp_reg;
    assign s_axi_rdata    = rdata_reg;

endmodule
`default_nettype wire

/* pdmc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the power-down controller.
// ****************************************************************
module pdmc_checker #(
    parameter int BUS_W = 24
) (
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             hwStandbyN,
    input wire logic             busCycleEnd,
    input wire logic [BUS_W-1:0] addrBusOut,
    input wire logic             addrBusOe,
    input wire logic             busStrobesOe,
    input wire logic             clkPinOut,
    input wire logic             clkPinOe,
    input wire logic             cpuHalted,
    input wire logic             oscStopped,
    input wire logic             serialAdcReset,
    input wire logic             portsHighZ,
    input wire logic [15:0]      moduleHalt,
    input wire logic             busMasterClkEn,
    input wire logic [2:0]       activeDivide
);
    // All checks run on the system clock and pause during reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Two cycles of software standby with the standby pin released.
    sequence s_standby;
        oscStopped && hwStandbyN ##1 oscStopped && hwStandbyN;
    endsequence
    // Two running cycles with an unchanged undivided selection.
    sequence s_full_rate;
        !oscStopped [*2] ##0 (activeDivide == 3'h0 && $stable(activeDivide));
    endsequence

    write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
        s_axi_awready |=> s_axi_bvalid) else $error("write answer missing");
    write_stands_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer dropped early");
    standby_stop_a: assert property (s_standby |-> serialAdcReset &&
        cpuHalted && !busMasterClkEn) else $error("standby not stopped");
    bus_hold_a: assert property (s_standby |-> $stable(addrBusOut))
        else $error("address bus moved in standby");
    bus_float_a: assert property (addrBusOe == busStrobesOe &&
        (oscStopped || addrBusOe)) else $error("bus floats while running");
    clk_pin_a: assert property (s_standby |-> clkPinOut)
        else $error("clock pin not high in standby");
    hw_float_a: assert property (!hwStandbyN |-> portsHighZ && !clkPinOe &&
        !addrBusOe && !busStrobesOe && oscStopped) else $error("pins driven");
    hw_clear_a: assert property (!hwStandbyN |=> moduleHalt == 16'h3fff &&
        activeDivide == 3'h0) else $error("registers kept in hw standby");
    wake_wait_a: assert property ($fell(oscStopped) && $past(hwStandbyN)
        |-> $past(oscStopped, 4)) else $error("settling wait too short");
    full_rate_a: assert property (s_full_rate |-> busMasterClkEn)
        else $error("undivided clock enable missing");
    divided_gap_a: assert property (busMasterClkEn && activeDivide != 3'h0
        && $stable(activeDivide) |=> !busMasterClkEn) else $error("no divide");
    divide_edge_a: assert property (!$stable(activeDivide) |->
        $past(busCycleEnd) || !$past(hwStandbyN)) else $error("divide early");
endmodule

bind pdmc_power_down_ctrl pdmc_checker #(.BUS_W(BUS_W)) uChk (
    .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .hwStandbyN, .busCycleEnd, .addrBusOut,
    .addrBusOe, .busStrobesOe, .clkPinOut, .clkPinOe, .cpuHalted,
    .oscStopped, .serialAdcReset, .portsHighZ, .moduleHalt,
    .busMasterClkEn, .activeDivide
);
`default_nettype wire

/* pdmc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Behavioural processor core facing the power-down controller.
// ****************************************************************
module pdmc_cpu_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        haltReq,
    input  wire logic        slowBus,
    input  wire logic        cpuHalted,
    output logic             haltExec,
    output logic             busCycleEnd,
    output logic [23:0]      addrBusIn,
    output logic [7:0]       busStrobesNIn
);
    logic [2:0] phaseCnt;

    // Bus cycles last one or four clocks; a halted core drives junk.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseCnt      <= 3'h0;
            haltExec      <= 1'b0;
            busCycleEnd   <= 1'b0;
            addrBusIn     <= 24'h0;
            busStrobesNIn <= 8'hff;
        end else begin
            phaseCnt      <= phaseCnt + 3'h1;
            haltExec      <= haltReq && !cpuHalted;
            busCycleEnd   <= !cpuHalted && (!slowBus || phaseCnt[1:0] == 2'h3);
            addrBusIn     <= cpuHalted ? ~addrBusIn : addrBusIn + 24'h1;
            busStrobesNIn <= ~(8'h01 << phaseCnt); // Changes every cycle.
        end
    end
endmodule
`default_nettype wire

/* tb_power_down_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_consts.svh"
module tb_power_down_mode_control;
    localparam int          WB    = 4;
    localparam logic [19:0] A_SBY = {2'h0, `PDMC_IDX_STANDBY, 2'h0};
    localparam logic [19:0] A_DIV = {2'h0, `PDMC_IDX_CLKDIV, 2'h0};
    localparam logic [19:0] A_HH  = {2'h0, `PDMC_IDX_HALT_HIGH, 2'h0};
    localparam logic [19:0] A_HL  = {2'h0, `PDMC_IDX_HALT_LOW, 2'h0};
    logic        ref_clk, rst_n, haltReq, slowBus, anyIrq, extIrq, hwStandbyN;
    logic [19:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, held;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, haltExec, busCycleEnd;
    logic [23:0] addrBusIn, addrBusOut;
    logic [7:0]  busStrobesNIn, busStrobesNOut, sby;
    logic        addrBusOe, busStrobesOe, clkPinOut, clkPinOe, cpuHalted;
    logic        oscStopped, serialAdcReset, portsHighZ, busMasterClkEn;
    logic [15:0] moduleHalt, hv;
    logic [2:0]  activeDivide;
    int          errorCnt, checksDone, cycles, cnt;

    pdmc_power_down_ctrl #(.WAIT_BASE(WB)) uut (.*);
    pdmc_cpu_model cpu (.*);

    // ****************************************************************
    // Clock, watchdog and reporting.
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // A hang counts as a mismatch and closes the run.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            printVerdict;
        end
    end

    task automatic printVerdict;
        if (errorCnt == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        chkVal({31'h0, got}, {31'h0, exp});
    endtask

    // Expected settling wait for a wait-select code.
    function automatic int waitStates(input logic [2:0] code);
        if (code == 3'h7) return 16;
        if (code == 3'h6) return WB;
        return WB << code;
    endfunction

    // ****************************************************************
    // Register bus master; each task starts and ends just after an edge.
    // ****************************************************************
    task automatic axiWrite(input logic [19:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic axiRead(input logic [19:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdChk(input logic [19:0] a, input logic [7:0] exp);
        axiRead(a);
        chkVal(rd, {24'h0, exp});
        chkVal(resp, 2'h0);
    endtask

    // The core model turns the request into one halt instruction.
    task automatic halt;
        haltReq <= 1'b1;
        @(posedge ref_clk);
        haltReq <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {errorCnt, checksDone, cycles} = '0;
        {rst_n, haltReq, slowBus, anyIrq, extIrq} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h1;
        hwStandbyN = 1'b1;
        void'($urandom(32'h718c));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chkVal({activeDivide, busMasterClkEn}, 4'h1);
        rdChk(A_SBY, 8'h08);
        rdChk(A_DIV, 8'h00);
        rdChk(A_HH, 8'h3f);
        rdChk(A_HL, 8'hff);
        axiRead(A_SBY + 20'h2);
        chkVal(resp, 2'h2);
        axiWrite(20'h10, 8'h55);
        chkVal(resp, 2'h2);
        axiWrite(A_SBY, 8'h07);
        rdChk(A_SBY, 8'h01);
        axiWrite(A_DIV, 8'hff);
        rdChk(A_DIV, 8'hc7);
        #18.75;
        chkBit(clkPinOut, 1'b1);
        @(posedge ref_clk);
        // Random module halt patterns reach the halt outputs.
        repeat (4) begin
            hv = 16'($urandom);
            axiWrite(A_HH, hv[15:8]);
            axiWrite(A_HL, hv[7:0]);
            chkVal(moduleHalt, hv);
        end
        // Every divide code, with prompt and slow bus cycles.
        for (int c = 0; c < 8; c++) begin
            slowBus <= 1'($urandom);
            axiWrite(A_DIV, 8'(c));
            if (c < 6) begin
                while (activeDivide !== 3'(c)) @(posedge ref_clk);
                repeat (2) @(posedge ref_clk);
                while (busMasterClkEn !== 1'b1) @(posedge ref_clk);
                cnt = 0;
                do begin
                    @(posedge ref_clk);
                    cnt++;
                end while (busMasterClkEn !== 1'b1);
                chkVal(cnt, 32'h1 << c);
            end else begin
                repeat (8) @(posedge ref_clk);
                chkVal(activeDivide, 3'h5);
            end
        end
        // Sleep while running divided, then an ordinary interrupt.
        axiWrite(A_DIV, 8'h02);
        axiWrite(A_SBY, 8'h08);
        while (activeDivide !== 3'h2) @(posedge ref_clk);
        halt;
        chkBit(cpuHalted, 1'b1);
        chkVal({oscStopped, serialAdcReset}, 2'h0);
        chkVal(moduleHalt, hv);
        anyIrq <= 1'b1;
        @(posedge ref_clk);
        anyIrq <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chkBit(cpuHalted, 1'b0);
        chkVal(activeDivide, 3'h2);
        // Every wait code is legal with an external clock.
        for (int c = 0; c < 8; c++) begin
            sby = {1'b1, 3'(c), 1'(c), 3'h0};
            axiWrite(A_SBY, sby);
            halt;
            held = {busStrobesNOut, addrBusOut};
            #68.75;
            chkBit(oscStopped, 1'b1);
            chkBit(serialAdcReset, 1'b1);
            chkBit(addrBusOe, sby[3]);
            chkBit(clkPinOut, 1'b1);
            chkVal({busStrobesNOut, addrBusOut}, held);
            @(posedge ref_clk);
            extIrq <= 1'b1;
            @(posedge ref_clk);
            extIrq <= 1'b0;
            cnt = 0;
            @(posedge ref_clk);
            while (cpuHalted === 1'b1) begin
                cnt++;
                @(posedge ref_clk);
            end
            chkVal(cnt, waitStates(3'(c)));
            rdChk(A_SBY, sby);
        end
        rdChk(A_DIV, 8'h02);
        chkVal(moduleHalt, hv);
        // Hardware standby floats the pins and clears the registers.
        hwStandbyN <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chkBit(portsHighZ, 1'b1);
        chkBit(clkPinOe, 1'b0);
        chkBit(addrBusOe, 1'b0);
        hwStandbyN <= 1'b1;
        @(posedge ref_clk);
        rdChk(A_SBY, 8'h08);
        rdChk(A_DIV, 8'h00);
        rdChk(A_HL, 8'hff);
        printVerdict;
    end
endmodule
`default_nettype wire
